/* File: src/mhfc_pkg.sv */
package mhfc_pkg;
  localparam int NPRIO_DEF = 8;
  localparam int TIME_W = 16;
  localparam int CLK_MHZ = 10;
  localparam int MBPS_10M = 10;
  localparam int MBPS_100M = 100;
  localparam int MBPS_1G = 1000;
  localparam int MBPS_2G5 = 2500;
  localparam logic [9:0] QUANTUM_BITS = 10'h200;
  localparam logic [9:0] BPC_10M = 10'(MBPS_10M / CLK_MHZ);
  localparam logic [9:0] BPC_100M = 10'(MBPS_100M / CLK_MHZ);
  localparam logic [9:0] BPC_1G = 10'(MBPS_1G / CLK_MHZ);
  localparam logic [9:0] BPC_2G5 = 10'(MBPS_2G5 / CLK_MHZ);

  typedef enum logic [1:0] {SPD_10M, SPD_100M, SPD_1G, SPD_2G5} mhfc_speed_t;
  typedef enum logic [1:0] {GAP_IDLE, GAP_CARRIER, GAP_PART1, GAP_PART2} mhfc_gap_t;

  localparam logic [7:0] OFS_HDX = 8'h00;
  localparam logic [7:0] OFS_IFG = 8'h04;
  localparam logic [7:0] OFS_MAXLEN = 8'h08;
  localparam logic [7:0] OFS_TAGS = 8'h0c;
  localparam logic [7:0] OFS_FC = 8'h10;
  localparam logic [7:0] OFS_LAT = 8'h14;
  localparam logic [7:0] OFS_PFC = 8'h18;
  localparam logic [7:0] OFS_SMAC_LO = 8'h1c;
  localparam logic [7:0] OFS_SMAC_HI = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;

  localparam int HDX_FDX = 0;
  localparam int HDX_WEXC = 1;
  localparam int HDX_RETRY = 2;
  localparam int HDX_SEED_LOAD = 3;
  localparam int HDX_SEED = 8;
  localparam int HDX_LATE_POS = 16;
  localparam int IFG_PART1 = 0;
  localparam int IFG_PART2 = 8;
  localparam int TAGS_ALLOW = 16;
  localparam int TAGS_SINGLE = 17;
  localparam int TAGS_DOUBLE = 18;
  localparam int TAGS_LEN_DROP = 19;
  localparam int FC_RX = 16;
  localparam int FC_TX = 17;
  localparam int FC_ZERO = 18;
  localparam int FC_DROP = 19;
  localparam int FC_SPEED = 20;
  localparam int PFC_TX = 8;
  localparam int PFC_PROT = 16;
  localparam int STAT_HALT = 8;
  localparam int STAT_GAP = 9;
  localparam int STAT_BACKOFF = 10;
  localparam int STAT_REQ = 11;
  localparam int STAT_ARMED = 12;
  localparam int STAT_ATTEMPTS = 16;

  localparam logic [15:0] RST_MAXLEN = 16'h05ee;
  localparam logic [15:0] RST_PTIME = 16'hffff;
  localparam logic [15:0] RST_LFSR = 16'hace1;
  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [15:0] LATE_BORDER = 16'h0038;
  localparam logic [15:0] TAG_LEN = 16'h0004;
  localparam logic [15:0] DTAG_LEN = 16'h0008;
  localparam logic [4:0] ATTEMPT_LIMIT = 5'h10;
  localparam logic [3:0] BACKOFF_LIMIT = 4'ha;
  localparam logic [7:0] PFC_VEC_ALL = 8'hff;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
endpackage

/* File: src/mhfc_core.sv */
// How it works
// [RL1] Backoff randomizer takes the seed only when software pulses seed load.
// [RL2] Backoff disable bit skips backoff after an excessive collision.
// [RL3] Retry bit keeps the frame after excessive collisions, restarting backoff.
// [RL4] Late border at data byte 56, moved one byte per position step.
// [RL5] Rx-to-Tx gap is part one plus part two; carrier restarts part one.
// [RL6] Carrier changes are ignored during part two of the gap.
// [RL7] Frames longer than the configured maximum length are oversize.
// [RL8] Length allowance adds 4 bytes single-tagged, 8 bytes double-tagged.
// [RL9] Tag recognised by 0x8100 or by the custom ethertype.
// [RL10] Single and double awareness choose zero, one or two tags.
// [RL11] Length-check drop discards frames with type/length errors.
// [RL12] Full duplex pause reception halts egress for the received time.
// [RL13] Flow-control assertion sends pause with configured time and source address.
// [RL14] Zero-pause cancel sends time 0 when flow control de-asserts.
// [RL15] After a sent pause and partner latency, incoming frame starts are discarded.
// [RL16] Half duplex ignores received pause and applies backpressure instead.
// [RL17] Priority pause reception pauses class n for time n when bit n set.
// [RL18] Priority pause sent for enabled classes whose watermark is exceeded.
// [RL19] Congested priorities carry the pause time, uncongested carry 0.
// [RL20] Protection mode pauses all lower priorities of a congested one.
// [RL21] Sent enable vector is always 0xff; disabled priorities carry 0.
// [RL22] Resend every half pause time while congested; no zero frame on clear.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module mhfc_core #(
  parameter int NPRIO = mhfc_pkg::NPRIO_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_crs,
  input wire logic i_coll,
  input wire logic [15:0] i_coll_byte,
  input wire logic i_tx_done,
  output logic o_retry_tx,
  output logic o_drop_tx,
  output logic o_late_coll,
  output logic o_backoff_busy,
  output logic o_gap_busy,
  output logic o_backpressure,
  input wire logic i_rx_eof,
  input wire logic [15:0] i_rx_len,
  input wire logic [15:0] i_rx_tpid1,
  input wire logic [15:0] i_rx_tpid2,
  input wire logic i_rx_len_err,
  output logic o_rx_oversize,
  output logic o_rx_drop,
  input wire logic i_rx_sof,
  output logic o_rx_sof_discard,
  input wire logic i_rx_pause_valid,
  input wire logic i_rx_pause_pfc,
  input wire logic [NPRIO-1:0] i_rx_pause_vec,
  input wire logic [NPRIO*mhfc_pkg::TIME_W-1:0] i_rx_pause_times,
  output logic o_egress_halt,
  output logic [NPRIO-1:0] o_prio_paused,
  input wire logic i_fc_cond,
  input wire logic [NPRIO-1:0] i_prio_cong,
  output logic o_pause_req,
  input wire logic i_pause_ack,
  input wire logic i_pause_done,
  output logic o_pause_pfc,
  output logic [NPRIO-1:0] o_pause_vec,
  output logic [NPRIO*mhfc_pkg::TIME_W-1:0] o_pause_times,
  output logic [47:0] o_pause_smac
);
  import mhfc_pkg::*;

  typedef struct packed {
    logic fdx;
    logic wexc;
    logic retry;
    logic [7:0] seed;
    logic [5:0] late_pos;
    logic [4:0] ifg1;
    logic [4:0] ifg2;
    logic [15:0] maxlen;
    logic [15:0] custom_tag_ethertype;
    logic vlan_allow;
    logic aw1;
    logic aw2;
    logic lendrop;
    logic prx;
    logic ptx;
    logic zero;
    logic fcdrop;
    mhfc_speed_t speed;
    logic [15:0] ptime;
    logic [15:0] latency;
    logic [NPRIO-1:0] pfc_rx;
    logic [NPRIO-1:0] pfc_tx;
    logic prot;
    logic [47:0] smac;
    logic [31:0] prdata;
    logic [9:0] acc;
    logic [15:0] lfsr;
    logic [4:0] attempts;
    logic [9:0] bo_cnt;
    logic retry_pend;
    logic retry_p;
    logic drop_p;
    logic late_p;
    logic bp;
    mhfc_gap_t gst;
    logic [4:0] gcnt;
    logic oversize_p;
    logic rxdrop_p;
    logic [15:0] std_t;
    logic [NPRIO-1:0][15:0] pt;
    logic fc_q;
    logic [NPRIO-1:0] cong_q;
    logic pend_std;
    logic pend_zero;
    logic pend_pfc;
    logic req;
    logic req_pfc;
    logic [NPRIO-1:0] req_vec;
    logic [NPRIO-1:0][15:0] req_times;
    logic [15:0] refresh;
    logic refresh_on;
    logic [15:0] lat_cnt;
    logic armed;
    logic sofdisc_p;
  } mhfc_state_t;

  mhfc_state_t q;
  mhfc_state_t d;
  logic [1:0] rst_q;
  logic rst_n;
  logic [10:0] sum;
  logic tick;
  logic wr;
  logic mapped;
  logic [31:0] rdat;
  logic [9:0] bpc;
  logic [4:0] n_att;
  logic [3:0] win;
  logic [9:0] mask;
  logic [15:0] extra;
  logic [15:0] allow;
  logic t1;
  logic t2;
  logic [NPRIO-1:0] en_cong;
  logic [NPRIO-1:0] eff;
  logic [NPRIO-1:0][15:0] tm;
  logic any_cong;

  // Reset released through two flops so its removal is clean
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_comb begin
    d = q;
    d.retry_p = 1'b0;
    d.drop_p = 1'b0;
    d.late_p = 1'b0;
    d.oversize_p = 1'b0;
    d.rxdrop_p = 1'b0;
    d.sofdisc_p = 1'b0;

    // Pause quantum and slot time share one 512-bit-time tick
    unique case (q.speed)
      SPD_10M: bpc = BPC_10M;
      SPD_100M: bpc = BPC_100M;
      SPD_1G: bpc = BPC_1G;
      SPD_2G5: bpc = BPC_2G5;
    endcase
    sum = {1'b0, q.acc} + {1'b0, bpc};
    tick = sum >= {1'b0, QUANTUM_BITS};
    d.acc = tick ? 10'(sum - {1'b0, QUANTUM_BITS}) : sum[9:0];
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};

    wr = i_psel & i_penable & i_pwrite;
    mapped = 1'b1;
    rdat = 32'h0;
    case (i_paddr)
      OFS_HDX: begin
        rdat[HDX_FDX] = q.fdx;
        rdat[HDX_WEXC] = q.wexc;
        rdat[HDX_RETRY] = q.retry;
        rdat[HDX_SEED+:8] = q.seed;
        rdat[HDX_LATE_POS+:6] = q.late_pos;
        if (wr) begin
          d.fdx = i_pwdata[HDX_FDX];
          d.wexc = i_pwdata[HDX_WEXC];
          d.retry = i_pwdata[HDX_RETRY];
          d.seed = i_pwdata[HDX_SEED+:8];
          d.late_pos = i_pwdata[HDX_LATE_POS+:6];
          if (i_pwdata[HDX_SEED_LOAD]) begin
            d.lfsr = {i_pwdata[HDX_SEED+:8], ~i_pwdata[HDX_SEED+:8]}; // [RL1]
          end
        end
      end
      OFS_IFG: begin
        rdat[IFG_PART1+:5] = q.ifg1;
        rdat[IFG_PART2+:5] = q.ifg2;
        if (wr) begin
          d.ifg1 = i_pwdata[IFG_PART1+:5];
          d.ifg2 = i_pwdata[IFG_PART2+:5];
        end
      end
      OFS_MAXLEN: begin
        rdat[15:0] = q.maxlen;
        if (wr) begin
          d.maxlen = i_pwdata[15:0];
        end
      end
      OFS_TAGS: begin
        rdat[15:0] = q.custom_tag_ethertype;
        rdat[TAGS_ALLOW] = q.vlan_allow;
        rdat[TAGS_SINGLE] = q.aw1;
        rdat[TAGS_DOUBLE] = q.aw2;
        rdat[TAGS_LEN_DROP] = q.lendrop;
        if (wr) begin
          d.custom_tag_ethertype = i_pwdata[15:0];
          d.vlan_allow = i_pwdata[TAGS_ALLOW];
          d.aw1 = i_pwdata[TAGS_SINGLE];
          d.aw2 = i_pwdata[TAGS_DOUBLE];
          d.lendrop = i_pwdata[TAGS_LEN_DROP];
        end
      end
      OFS_FC: begin
        rdat[15:0] = q.ptime;
        rdat[FC_RX] = q.prx;
        rdat[FC_TX] = q.ptx;
        rdat[FC_ZERO] = q.zero;
        rdat[FC_DROP] = q.fcdrop;
        rdat[FC_SPEED+:2] = q.speed;
        if (wr) begin
          d.ptime = i_pwdata[15:0];
          d.prx = i_pwdata[FC_RX];
          d.ptx = i_pwdata[FC_TX];
          d.zero = i_pwdata[FC_ZERO];
          d.fcdrop = i_pwdata[FC_DROP];
          d.speed = mhfc_speed_t'(i_pwdata[FC_SPEED+:2]);
        end
      end
      OFS_LAT: begin
        rdat[15:0] = q.latency;
        if (wr) begin
          d.latency = i_pwdata[15:0];
        end
      end
      OFS_PFC: begin
        rdat[NPRIO-1:0] = q.pfc_rx;
        rdat[PFC_TX+:NPRIO] = q.pfc_tx;
        rdat[PFC_PROT] = q.prot;
        if (wr) begin
          d.pfc_rx = i_pwdata[NPRIO-1:0];
          d.pfc_tx = i_pwdata[PFC_TX+:NPRIO];
          d.prot = i_pwdata[PFC_PROT];
        end
      end
      OFS_SMAC_LO: begin
        rdat = q.smac[31:0];
        if (wr) begin
          d.smac[31:0] = i_pwdata;
        end
      end
      OFS_SMAC_HI: begin
        rdat[15:0] = q.smac[47:32];
        if (wr) begin
          d.smac[47:32] = i_pwdata[15:0];
        end
      end
      OFS_STAT: begin
        rdat[NPRIO-1:0] = o_prio_paused;
        rdat[STAT_HALT] = o_egress_halt;
        rdat[STAT_GAP] = o_gap_busy;
        rdat[STAT_BACKOFF] = o_backoff_busy;
        rdat[STAT_REQ] = q.req;
        rdat[STAT_ARMED] = q.armed;
        rdat[STAT_ATTEMPTS+:5] = q.attempts;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    // Read data captured in setup so the access phase needs no wait
    if (i_psel & ~i_penable) begin
      d.prdata = rdat;
    end

    // Half-duplex collision handling and backoff
    n_att = q.attempts + 5'h1;
    win = (n_att >= {1'b0, BACKOFF_LIMIT}) ? BACKOFF_LIMIT : n_att[3:0];
    mask = ~(10'h3ff << win);
    if (tick && q.bo_cnt != 10'h0) begin
      d.bo_cnt = q.bo_cnt - 10'h1;
    end
    if (q.retry_pend && q.bo_cnt == 10'h0) begin
      d.retry_p = 1'b1;
      d.retry_pend = 1'b0;
    end
    if (i_tx_done) begin
      d.attempts = 5'h0;
    end
    if (i_coll && !q.fdx) begin
      if (i_coll_byte > LATE_BORDER + {10'h0, q.late_pos}) begin
        d.late_p = 1'b1; // [RL4]
        d.drop_p = 1'b1;
        d.attempts = 5'h0;
        d.retry_pend = 1'b0;
      end else if (n_att == ATTEMPT_LIMIT) begin
        d.attempts = 5'h0;
        d.bo_cnt = q.wexc ? 10'h0 : (q.lfsr[9:0] & mask); // [RL2]
        d.retry_pend = q.retry; // [RL3]
        d.drop_p = ~q.retry;
      end else begin
        d.attempts = n_att;
        d.bo_cnt = q.lfsr[9:0] & mask;
        d.retry_pend = 1'b1;
      end
    end
    d.bp = ~q.fdx & i_fc_cond; // [RL16]

    // Rx-to-Tx gap, counted in clock cycles
    if (q.gcnt != 5'h0) begin
      d.gcnt = q.gcnt - 5'h1;
    end
    unique case (q.gst)
      GAP_IDLE: begin
        if (!q.fdx && i_crs) begin
          d.gst = GAP_CARRIER;
        end
      end
      GAP_CARRIER: begin
        if (!i_crs) begin
          d.gst = GAP_PART1;
          d.gcnt = q.ifg1;
        end
      end
      GAP_PART1: begin
        if (i_crs) begin
          d.gst = GAP_CARRIER; // [RL5]
        end else if (q.gcnt == 5'h0) begin
          d.gst = GAP_PART2;
          d.gcnt = q.ifg2;
        end
      end
      GAP_PART2: begin
        if (q.gcnt == 5'h0) begin
          d.gst = GAP_IDLE; // [RL6]
        end
      end
    endcase

    // Frame length and tag check at end of frame
    t1 = q.aw1 & (i_rx_tpid1 == VLAN_TPID | i_rx_tpid1 == q.custom_tag_ethertype); // [RL9] [RL10]
    t2 = t1 & q.aw2 & (i_rx_tpid2 == VLAN_TPID | i_rx_tpid2 == q.custom_tag_ethertype); // [RL10]
    extra = 16'h0;
    if (q.vlan_allow) begin
      extra = t2 ? DTAG_LEN : (t1 ? TAG_LEN : 16'h0); // [RL8]
    end
    allow = q.maxlen + extra;
    if (i_rx_eof) begin
      d.oversize_p = i_rx_len > allow; // [RL7]
      d.rxdrop_p = (i_rx_len > allow) | (q.lendrop & i_rx_len_err); // [RL11]
    end

    // Received pause timers, one quantum per tick
    if (tick && q.std_t != 16'h0) begin
      d.std_t = q.std_t - 16'h1;
    end
    for (int n = 0; n < NPRIO; n++) begin
      if (tick && q.pt[n] != 16'h0) begin
        d.pt[n] = q.pt[n] - 16'h1;
      end
    end
    if (i_rx_pause_valid && q.fdx) begin // [RL16]
      if (!i_rx_pause_pfc && q.prx) begin
        d.std_t = i_rx_pause_times[15:0]; // [RL12]
      end
      for (int n = 0; n < NPRIO; n++) begin
        if (i_rx_pause_pfc && q.pfc_rx[n] && i_rx_pause_vec[n]) begin
          d.pt[n] = i_rx_pause_times[TIME_W*n+:TIME_W]; // [RL17]
        end
      end
    end

    // Pause frame generation
    en_cong = i_prio_cong & q.pfc_tx; // [RL18]
    any_cong = |en_cong;
    for (int n = 0; n < NPRIO; n++) begin
      eff[n] = q.prot ? |(en_cong >> n) : en_cong[n]; // [RL20]
      tm[n] = (eff[n] & q.pfc_tx[n]) ? q.ptime : PAUSE_ZERO; // [RL19] [RL21]
    end
    d.fc_q = i_fc_cond;
    d.cong_q = en_cong;
    if (!q.req) begin
      if (q.pend_pfc) begin
        d.req = 1'b1;
        d.req_pfc = 1'b1;
        d.req_vec = PFC_VEC_ALL; // [RL21]
        d.req_times = tm;
        d.pend_pfc = 1'b0;
        d.refresh_on = any_cong;
        d.refresh = q.ptime >> 1; // [RL22]
      end else if (q.pend_std | q.pend_zero) begin
        d.req = 1'b1;
        d.req_pfc = 1'b0;
        d.req_vec = '0;
        d.req_times = '0;
        d.req_times[0] = q.fc_q ? q.ptime : PAUSE_ZERO; // [RL13] [RL14]
        d.pend_std = 1'b0;
        d.pend_zero = 1'b0;
      end
    end else if (i_pause_ack) begin
      d.req = 1'b0;
    end
    // Sets follow the clears so a same-cycle event is kept
    if (q.fdx && q.ptx && i_fc_cond && !q.fc_q) begin
      d.pend_std = 1'b1; // [RL13]
    end
    if (q.fdx && q.ptx && q.zero && !i_fc_cond && q.fc_q) begin
      d.pend_zero = 1'b1; // [RL14]
    end
    if (q.fdx && |(en_cong & ~q.cong_q)) begin
      d.pend_pfc = 1'b1; // [RL18]
    end
    if (q.refresh_on) begin
      if (!any_cong) begin
        d.refresh_on = 1'b0; // [RL22]
      end else if (q.refresh == 16'h0) begin
        d.refresh_on = 1'b0;
        d.pend_pfc = 1'b1; // [RL22]
      end else if (tick) begin
        d.refresh = q.refresh - 16'h1;
      end
    end

    // Discard of partner frames after the reaction latency
    if (i_pause_done) begin
      d.armed = q.fcdrop & (|q.req_times); // [RL15]
      d.lat_cnt = q.latency;
    end else if (q.armed) begin
      if (q.lat_cnt != 16'h0) begin
        d.lat_cnt = q.lat_cnt - 16'h1;
      end
      if (!i_fc_cond && !any_cong) begin
        d.armed = 1'b0;
      end
    end
    if (q.armed && q.fcdrop && q.lat_cnt == 16'h0 && i_rx_sof) begin
      d.sofdisc_p = 1'b1; // [RL15]
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.maxlen <= RST_MAXLEN;
      q.custom_tag_ethertype <= VLAN_TPID;
      q.ptime <= RST_PTIME;
      q.lfsr <= RST_LFSR;
    end else begin
      q <= d;
    end
  end

  // Flag per priority from its own timer
  for (genvar g = 0; g < NPRIO; g++) begin : g_prio
    assign o_prio_paused[g] = q.pt[g] != 16'h0; // [RL17]
  end

  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_retry_tx = q.retry_p;
  assign o_drop_tx = q.drop_p;
  assign o_late_coll = q.late_p;
  assign o_backoff_busy = q.retry_pend | (q.bo_cnt != 10'h0);
  assign o_gap_busy = q.gst != GAP_IDLE;
  assign o_backpressure = q.bp;
  assign o_rx_oversize = q.oversize_p;
  assign o_rx_drop = q.rxdrop_p;
  assign o_rx_sof_discard = q.sofdisc_p;
  assign o_egress_halt = q.std_t != 16'h0; // [RL12]
  assign o_pause_req = q.req;
  assign o_pause_pfc = q.req_pfc;
  assign o_pause_vec = q.req_vec;
  assign o_pause_times = q.req_times;
  assign o_pause_smac = q.smac; // [RL13]
endmodule
`default_nettype wire

/* File: testbench/mhfc_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module mhfc_partner (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_done
);
  logic [4:0] cnt_q;
  // Slow mode leaves the request unacknowledged for 21 cycles
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack <= 1'b0;
      o_done <= 1'b0;
      cnt_q <= 5'h0;
    end else begin
      o_ack <= 1'b0;
      o_done <= o_ack;
      cnt_q <= 5'h0;
      if (i_req && !o_ack) begin
        cnt_q <= cnt_q + 5'h1;
        o_ack <= cnt_q >= (i_slow ? 5'h14 : 5'h1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/mhfc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module mhfc_checker #(
  parameter int NPRIO = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rx_eof,
  input wire logic i_rx_sof,
  input wire logic i_rx_pause_valid,
  input wire logic i_rx_pause_pfc,
  input wire logic i_fc_cond,
  input wire logic i_pause_ack,
  input wire logic o_rx_oversize,
  input wire logic o_rx_drop,
  input wire logic o_rx_sof_discard,
  input wire logic o_late_coll,
  input wire logic o_drop_tx,
  input wire logic o_backpressure,
  input wire logic o_egress_halt,
  input wire logic [NPRIO-1:0] o_prio_paused,
  input wire logic o_pause_req,
  input wire logic o_pause_pfc,
  input wire logic [NPRIO-1:0] o_pause_vec,
  input wire logic [NPRIO*mhfc_pkg::TIME_W-1:0] o_pause_times,
  input wire logic [47:0] o_pause_smac
);
  import mhfc_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_wait;
    o_pause_req && !i_pause_ack;
  endsequence
  sequence s_taken;
    o_pause_req && i_pause_ack;
  endsequence
  a_oversize_drop: assert property (o_rx_oversize |-> o_rx_drop)
    else $error("oversize frame kept");
  a_drop_cause: assert property (o_rx_drop |-> $past(i_rx_eof))
    else $error("drop without frame end");
  a_discard_cause: assert property (o_rx_sof_discard |-> $past(i_rx_sof))
    else $error("discard without frame start");
  a_late_drop: assert property (o_late_coll |-> o_drop_tx)
    else $error("late collision kept frame");
  a_vec_all: assert property (o_pause_req && o_pause_pfc |-> o_pause_vec == 8'hff)
    else $error("priority vector not all ones");
  a_fields_hold: assert property (s_wait |=> o_pause_req && $stable(o_pause_times)
    && $stable(o_pause_smac) && $stable(o_pause_pfc))
    else $error("pause request changed before taken");
  a_req_release: assert property (s_taken |=> !o_pause_req)
    else $error("pause request held after taken");
  a_bp_follow: assert property (o_backpressure |-> $past(i_fc_cond))
    else $error("backpressure without condition");
  a_halt_cause: assert property ($rose(o_egress_halt)
    |-> $past(i_rx_pause_valid && !i_rx_pause_pfc))
    else $error("halt without pause frame");
  a_prio_cause: assert property (|(o_prio_paused & ~$past(o_prio_paused))
    |-> $past(i_rx_pause_valid && i_rx_pause_pfc))
    else $error("class paused without frame");
endmodule
bind mhfc_core mhfc_checker #(.NPRIO(NPRIO)) i_chk (.*);
`default_nettype wire

/* File: testbench/mhfc_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module mhfc_core_tb;
  import mhfc_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic o_pready, o_pslverr, i_crs = 0, i_coll = 0, i_tx_done = 0, err;
  logic [15:0] i_coll_byte = 0, i_rx_len = 0, i_rx_tpid1 = 0, i_rx_tpid2 = 0;
  logic o_retry_tx, o_drop_tx, o_late_coll, o_backoff_busy, o_gap_busy, o_backpressure;
  logic i_rx_eof = 0, i_rx_len_err = 0, o_rx_oversize, o_rx_drop, i_rx_sof = 0;
  logic o_rx_sof_discard, i_rx_pause_valid = 0, i_rx_pause_pfc = 0, o_egress_halt;
  logic [7:0] i_rx_pause_vec = 0, o_prio_paused, i_prio_cong = 0, o_pause_vec;
  logic [127:0] i_rx_pause_times = 0, o_pause_times;
  logic i_fc_cond = 0, o_pause_req, i_pause_ack, i_pause_done, o_pause_pfc, slow = 0;
  logic eof_d = 0;
  logic [47:0] o_pause_smac;
  logic [1:0] len_q[$];
  logic [128:0] pause_q[$];
  int num_errors = 0, n_tests = 0, seed = 34223, n;
  mhfc_core i_dut (.*);
  mhfc_partner i_far (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(o_pause_req),
    .i_slow(slow), .o_ack(i_pause_ack), .o_done(i_pause_done));
  initial forever #50 i_clk = ~i_clk;
  task automatic results;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [128:0] e, input logic [128:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k == 20) begin
      chk("pready", 1, 0);
      results;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic wait_q;
    int k;
    for (k = 0; k < 900 && pause_q.size() > 0; k++) @(posedge i_clk);
    if (k == 900) begin
      chk("pause frame", 1, 0);
      results;
    end
  endtask
  task automatic sof(input logic e);
    @(posedge i_clk);
    i_rx_sof <= 1;
    @(posedge i_clk);
    i_rx_sof <= 0;
    #1 chk("discard", e, o_rx_sof_discard);
  endtask
  task automatic pv(input logic f, input logic [7:0] v, input logic [127:0] t);
    @(posedge i_clk);
    i_rx_pause_pfc <= f;
    i_rx_pause_vec <= v;
    i_rx_pause_times <= t;
    i_rx_pause_valid <= 1;
    @(posedge i_clk);
    i_rx_pause_valid <= 0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic coll(input logic [15:0] b, input logic late);
    int k;
    @(posedge i_clk);
    i_coll_byte <= b;
    i_coll <= 1;
    @(posedge i_clk);
    i_coll <= 0;
    #1 chk("late", {late, late}, {o_late_coll, o_drop_tx});
    for (k = 0; k < 600 && !late && o_retry_tx !== 1'b1; k++) @(posedge i_clk) #1;
    chk("retry", 1, k < 600);
    @(posedge i_clk);
    i_tx_done <= 1;
    @(posedge i_clk);
    i_tx_done <= 0;
  endtask
  function automatic logic [1:0] len_exp(input logic [3:0] c, input logic [15:0] l,
    input logic [15:0] p, input logic [15:0] q, input logic e);
    logic a, b;
    logic [15:0] x;
    a = c[1] && (p == 16'h8100 || p == 16'h9100);
    b = a && c[2] && (q == 16'h8100 || q == 16'h9100);
    x = 16'h64 + (c[0] ? (b ? 16'h8 : a ? 16'h4 : 16'h0) : 16'h0);
    return {l > x, l > x || (c[3] && e)};
  endfunction
  // Classes 0 to 5 enabled, pause time 0x40
  function automatic logic [128:0] pfc_exp(input logic [7:0] cg, input logic pr);
    logic [128:0] r;
    r = {1'b1, 128'h0};
    for (int i = 0; i < 6; i++)
      if (pr ? |(cg[5:0] >> i) : cg[i]) r[16*i +: 16] = 16'h40;
    return r;
  endfunction
  always @(posedge i_clk) begin
    eof_d <= i_rx_eof;
    if (eof_d) begin
      if (len_q.size() == 0) chk("length none", 0, 1);
      else chk("length flags", len_q.pop_front(), {o_rx_oversize, o_rx_drop});
    end
    if (o_pause_req === 1'b1 && i_pause_ack === 1'b1) begin
      if (pause_q.size() == 0) chk("pause none", 0, 1);
      else chk("pause frame", pause_q.pop_front(), {o_pause_pfc, o_pause_times});
      chk("smac", 48'h0e0f0a0b0c0d, o_pause_smac);
    end
  end
  initial begin
    logic [15:0] p, q, l;
    logic e;
    logic [15:0] tp[3];
    tp = '{16'h8100, 16'h9100, 16'h0800};
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1;
    repeat (3) @(posedge i_clk);
    apb(0, OFS_MAXLEN, 0);
    chk("maxlen reset", 32'h05ee, rd);
    apb(0, OFS_TAGS, 0);
    chk("custom_tag_ethertype reset", 32'h8100, rd);
    apb(0, 8'h40, 0);
    chk("unmapped", 33'h100000000, {err, rd});
    apb(1, OFS_MAXLEN, 32'h64);
    for (int c = 0; c < 16; c++) begin
      apb(1, OFS_TAGS, {12'h0, 4'(c), 16'h9100});
      repeat (4) begin
        @(posedge i_clk);
        p = tp[$unsigned($random(seed)) % 3];
        q = tp[$unsigned($random(seed)) % 3];
        l = 16'h5e + 16'($unsigned($random(seed)) % 22);
        e = 1'($random(seed));
        i_rx_len <= l;
        i_rx_tpid1 <= p;
        i_rx_tpid2 <= q;
        i_rx_len_err <= e;
        i_rx_eof <= 1;
        len_q.push_back(len_exp(4'(c), l, p, q, e));
        @(posedge i_clk);
        i_rx_eof <= 0;
      end
    end
    apb(1, OFS_SMAC_LO, 32'h0a0b0c0d);
    apb(1, OFS_SMAC_HI, 32'h0e0f);
    apb(1, OFS_LAT, 32'h5);
    apb(1, OFS_HDX, 32'h1);
    apb(1, OFS_PFC, 32'h3fff);
    apb(1, OFS_FC, 32'h3f0040);
    pause_q.push_back(129'h40);
    i_fc_cond <= 1;
    wait_q;
    sof(0);
    repeat (20) @(posedge i_clk);
    sof(1);
    @(posedge i_clk);
    slow <= 1;
    pause_q.push_back(129'h0);
    i_fc_cond <= 0;
    wait_q;
    slow <= 0;
    pause_q.push_back(pfc_exp(8'h0a, 0));
    i_prio_cong <= 8'h0a;
    wait_q;
    pause_q.push_back(pfc_exp(8'h0a, 0));
    wait_q;
    i_prio_cong <= 0;
    repeat (1200) @(posedge i_clk);
    apb(1, OFS_PFC, 32'h13fff);
    pause_q.push_back(pfc_exp(8'h90, 1));
    i_prio_cong <= 8'h90;
    wait_q;
    i_prio_cong <= 0;
    pv(0, 8'h0, 128'h80);
    repeat (150) @(posedge i_clk);
    #1 chk("halt", 1, o_egress_halt);
    repeat (300) @(posedge i_clk);
    #1 chk("halt end", 0, o_egress_halt);
    pv(1, 8'h05, {8{16'h10}});
    chk("paused", 8'h05, o_prio_paused);
    apb(1, OFS_HDX, 32'h0);
    apb(1, OFS_FC, 32'h310004);
    pv(0, 8'h0, 128'h2);
    chk("hdx halt", 0, o_egress_halt);
    @(posedge i_clk);
    i_fc_cond <= 1;
    repeat (2) @(posedge i_clk);
    #1 chk("backpressure", 1, o_backpressure);
    @(posedge i_clk);
    i_fc_cond <= 0;
    coll(16'h39, 1);
    coll(16'h38, 0);
    apb(1, OFS_HDX, 32'h10000);
    coll(16'h39, 0);
    coll(16'h3a, 1);
    apb(1, OFS_IFG, 32'h0403);
    @(posedge i_clk);
    i_crs <= 1;
    repeat (3) @(posedge i_clk);
    i_crs <= 0;
    repeat (2) @(posedge i_clk);
    i_crs <= 1;
    @(posedge i_clk);
    i_crs <= 0;
    // Pulse at n 6 falls in part two and must not stretch the gap
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      i_crs <= (n == 6);
      #1;
      if (o_gap_busy !== 1'b1) break;
    end
    chk("gap length", 1, n >= 7 && n <= 12);
    repeat (4) @(posedge i_clk);
    chk("queues", 0, len_q.size() + pause_q.size());
    results;
  end
endmodule
`default_nettype wire
